//--- agcl_pkg.sv
// Package with constants shared by the gain control loop files.
package agcl_pkg;
    // Register offsets on the control port.
    localparam logic [2:0] REG_GAIN_HI   = 3'h3;
    localparam logic [2:0] REG_GAIN_LO   = 3'h4;
    localparam logic [2:0] REG_ATK_DCY   = 3'h5;
    localparam logic [2:0] REG_LOOP_CTL  = 3'h6;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    // Field positions.
    localparam int ATK_LSB     = 4;
    localparam int DCY_LSB     = 0;
    localparam int AUX_BIT     = 7;
    localparam int OVL_LSB     = 4;
    localparam int FAST_BIT    = 3;
    localparam int REF_LSB     = 0;
    localparam int FRONT_BIT   = 7;
    // Loop update divider: one loop tick per this many sample clocks.
    localparam int LOOP_DIV    = 60;
    // Reference level decode: five targets, 3 dB apart.
    localparam int REF_MAX     = 5;
    // Gain accumulator: 15-bit word plus fraction bits.
    localparam int ACC_FRAC    = 16;
    localparam int ACC_W       = 15 + ACC_FRAC;
    localparam logic [14:0] GAIN_MAX_DIGITAL_GAIN_STAGE  = 15'h7FFF;
    localparam logic [14:0] GAIN_MAX_PLAIN = 15'h3FFF;
    // Step scale shifts; attack step uses 2^(code/2) with a half-step factor.
    // Shifts are sized so a full 12 dB slew takes about as many loop ticks as the attack
    // and reset ramp times ask for; smaller shifts would leave the loop far too slow.
    localparam int ATK_BASE_SH = 19;
    localparam int OVL_BASE_SH = 20;
    // Attack bandwidth and time figures at the reference clock.
    localparam int BW_MIN_HZ     = 50;
    localparam int FCLK_REF_MHZ  = 18;
    localparam int T_ATK_K_MILLI = 350;
endpackage : agcl_pkg

//--- agcl_mag_est.sv
// Magnitude estimator: sum of absolute I and Q values.
`timescale 1ns/1ps
`default_nettype none
module agcl_mag_est
    import agcl_pkg::*;
#(
    parameter int W = 24
)(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] i_i,
    input  wire logic [W-1:0] q_i,
    output logic      [W:0]   mag_o
);
    wire [W-1:0] abs_i = i_i[W-1] ? (~i_i + 1'b1) : i_i;
    wire [W-1:0] abs_q = q_i[W-1] ? (~q_i + 1'b1) : q_i;
    wire [W:0]   sum   = {1'b0, abs_i} + {1'b0, abs_q};

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            mag_o <= '0;
        else if (en_i)
            mag_o <= sum;
    end
endmodule : agcl_mag_est
`default_nettype wire

//--- agcl_shaper.sv
// First order noise shaped truncation of one 24-bit lane to 16 bits.
`timescale 1ns/1ps
`default_nettype none
module agcl_shaper
    import agcl_pkg::*;
#(
    parameter int IW = 24,
    parameter int OW = 16
)(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          vld_i,
    input  wire logic [IW-1:0] d_i,
    output logic      [OW-1:0] q_o
);
    localparam int EW = IW - OW;
    logic [EW-1:0] err;
    // Error feedback pushes quantisation noise out of band.
    wire  [IW:0]   fed  = {d_i[IW-1], d_i} + {{(OW+1){1'b0}}, err};
    wire           ovf  = (fed[IW] != fed[IW-1]);
    wire  [OW-1:0] sat  = d_i[IW-1] ? {1'b1, {(OW-1){1'b0}}} : {1'b0, {(OW-1){1'b1}}};

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            err <= '0;
            q_o <= '0;
        end
        else if (vld_i)
        begin
            err <= ovf ? '0 : fed[EW-1:0];
            q_o <= ovf ? sat : fed[IW-1:EW];
        end
    end
endmodule : agcl_shaper
`default_nettype wire

//--- agcl_loop.sv
// Gain control loop core: registers, estimators, loop filter and digital gain.
// Behaviour
// - Four-bit attack code sets raw loop bandwidth, 50 Hz minimum at 18 MHz.
// - Each attack step multiplies bandwidth by root two, up to about 9 kHz.
// - Attack bandwidth is 50 Hz times clock ratio times two to half code.
// - Attack time is about 0.35 over attack bandwidth, single pole loop.
// - Four-bit decay code sets decay to attack ratio, code zero gives one.
// - Each decay step multiplies decay time by root two, about 180:1 range; above the attack code the code doubles it only every second step.
// - Three-bit overload weight scales reset attenuation, doubling per step.
// - After converter reset attenuation ramps 12 dB in 10 us to 1.2 ms.
// - Fast acquire bit lowers gain DAC source resistance at least tenfold.
// - Digital gain follows the larger of first decimator and gain output estimates.
// - Digital gain multiplies decimated data by one to four.
// - At gain four output drops two top bits, keeps next sixteen.
// - Gain falls as level rises; unity gain outputs top sixteen bits.
// - Beyond unity digital gain, attenuation moves to the analog path.
// - Noise shaping precedes truncation of 24-bit data to 16 bits.
// - Reference zero disables loop; 1 to 5 set target 3 to 15 dB below clip.
// - Loop runs and updates its state once every 60 sample clocks.
// - Too large raises attenuation by attack; too small lowers by attack minus decay.
// - Magnitude estimate is sum of absolute in-phase and quadrature values.
`timescale 1ns/1ps
`default_nettype none
module agcl_loop
    import agcl_pkg::*;
#(
    parameter int DW = 24,
    parameter int OW = 16
)(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          reg_wr_i,
    input  wire logic [2:0]    reg_addr_i,
    input  wire logic [7:0]    reg_wdata_i,
    output logic      [7:0]    reg_rdata_o,
    input  wire logic          digital_gain_stage_en_i,
    input  wire logic          adc_reset_i,
    input  wire logic [DW-1:0] first_decimator_i_i,
    input  wire logic [DW-1:0] first_decimator_q_i,
    input  wire logic          dec_vld_i,
    input  wire logic [DW-1:0] dec_i_i,
    input  wire logic [DW-1:0] dec_q_i,
    output logic               out_vld_o,
    output logic      [OW-1:0] out_i_o,
    output logic      [OW-1:0] out_q_o,
    output logic      [DW-1:0] wide_i_o,
    output logic      [DW-1:0] wide_q_o,
    output logic      [7:0]    vga_dac_o,
    output logic               fast_acquire_o,
    output logic               front_attenuator_o,
    output logic               loop_aux_bit_o
);
    logic [7:0]       r_gain_hi;
    logic [7:0]       r_gain_lo;
    logic [7:0]       r_atk_dcy;
    logic [7:0]       r_ctl;
    logic [5:0]       div_cnt;
    logic             tick;
    logic [ACC_W-1:0] acc;
    logic [DW-1:0]    g_i;
    logic [DW-1:0]    g_q;
    logic             g_vld;
    logic [DW:0]      mag1;
    logic [DW:0]      mag2;

    wire [3:0] attack_code     = r_atk_dcy[ATK_LSB +: 4];
    wire [3:0] decay_code      = r_atk_dcy[DCY_LSB +: 4];
    wire [2:0] overload_weight = r_ctl[OVL_LSB +: 3];
    wire [2:0] reference_level = r_ctl[REF_LSB +: 3];
    wire       loop_on         = (reference_level != 3'd0) && (reference_level <= 3'(REF_MAX));

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            div_cnt <= '0;
        else
            div_cnt <= (div_cnt == 6'(LOOP_DIV - 1)) ? 6'd0 : div_cnt + 6'd1;
    end
    assign tick = (div_cnt == 6'(LOOP_DIV - 1));

    // Register port; with the loop off, writes to the gain word also preset the loop accumulator.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r_gain_hi <= REG_RESET_VAL;
            r_gain_lo <= REG_RESET_VAL;
            r_atk_dcy <= REG_RESET_VAL;
            r_ctl     <= REG_RESET_VAL;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                REG_GAIN_HI:  r_gain_hi <= reg_wdata_i;
                REG_GAIN_LO:  r_gain_lo <= reg_wdata_i;
                REG_ATK_DCY:  r_atk_dcy <= reg_wdata_i;
                REG_LOOP_CTL: r_ctl     <= reg_wdata_i;
                default:      ;
            endcase
        end
    end

    wire [14:0] gain_word = loop_on ? acc[ACC_W-1 -: 15] : {r_gain_hi[6:0], r_gain_lo};
    assign reg_rdata_o = (reg_addr_i == REG_GAIN_HI)  ? {r_gain_hi[FRONT_BIT], gain_word[14:8]} :
                         (reg_addr_i == REG_GAIN_LO)  ? gain_word[7:0] :
                         (reg_addr_i == REG_ATK_DCY)  ? r_atk_dcy :
                         (reg_addr_i == REG_LOOP_CTL) ? r_ctl : 8'h00;

    agcl_mag_est #(.W(DW)) u_est1 (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (1'b1),
        .i_i     (first_decimator_i_i),
        .q_i     (first_decimator_q_i),
        .mag_o   (mag1)
    );
    agcl_mag_est #(.W(DW)) u_est2 (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (g_vld),
        .i_i     (g_i),
        .q_i     (g_q),
        .mag_o   (mag2)
    );

    wire [DW:0]  est      = (digital_gain_stage_en_i && mag2 > mag1) ? mag2 : mag1;
    // target 3 dB steps below clip
    wire [DW:0]  clip     = {2'b00, {(DW-1){1'b1}}};
    wire [DW:0]  tgt_a    = clip >> (reference_level >> 1);
    wire [DW:0]  target   = reference_level[0] ? (tgt_a - (tgt_a >> 2) - (tgt_a >> 4)) : tgt_a;
    wire         too_big  = est > target;

    // half-step by root two approximated as one plus 3/8
    function automatic logic [ACC_W-1:0] pow_step(input logic [4:0] code, input int base);
        logic [ACC_W-1:0] v;
        v = ACC_W'(1) << (base + code[4:1]);
        if (code[0])
            v = v + (v >> 2) + (v >> 3);
        return v;
    endfunction

    wire [ACC_W-1:0] up_step   = pow_step({1'b0, attack_code}, ATK_BASE_SH);
    // decay divides step by root two per code up to the attack code, by two per pair of codes above it
    wire [4:0]       dn_code   = (attack_code >= decay_code) ? 5'(attack_code - decay_code) : 5'd0;
    wire [ACC_W-1:0] dn_pow    = pow_step(dn_code, ATK_BASE_SH);
    wire [ACC_W-1:0] dn_step   = (decay_code > attack_code) ? (dn_pow >> ((decay_code - attack_code) >> 1)) : dn_pow;
    wire [ACC_W-1:0] ovl_step  = ACC_W'(3) << (OVL_BASE_SH + overload_weight);
    wire [ACC_W-1:0] max_acc   = digital_gain_stage_en_i ? {GAIN_MAX_DIGITAL_GAIN_STAGE, {ACC_FRAC{1'b1}}} :
                                             {GAIN_MAX_PLAIN, {ACC_FRAC{1'b1}}};
    wire [ACC_W-1:0] inc       = up_step + (adc_reset_i ? ovl_step : '0);
    wire [ACC_W:0]   sum_up    = {1'b0, acc} + {1'b0, inc};
    wire [ACC_W-1:0] acc_up    = (sum_up > {1'b0, max_acc}) ? max_acc : sum_up[ACC_W-1:0];
    wire [ACC_W-1:0] acc_dn    = (acc > dn_step) ? (acc - dn_step) : '0;
    wire [ACC_W-1:0] next_acc  = (too_big || adc_reset_i) ? acc_up : acc_dn;

    // Manual gain word loads the accumulator when the loop is off.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            acc <= '0;
        else if (!loop_on)
            acc <= {r_gain_hi[6:0], r_gain_lo, {ACC_FRAC{1'b0}}} & max_acc;
        else if (tick)
            acc <= next_acc;
    end

    // analog path above unity
    // Below 0x4000 with digital gain on, attenuation lives entirely in the digital stage.
    wire [14:0] g15     = acc[ACC_W-1 -: 15];
    wire [13:0] dg_att  = (digital_gain_stage_en_i && !g15[14]) ? ~g15[13:0] : 14'd0;
    wire [13:0] an_att  = digital_gain_stage_en_i ? (g15[14] ? g15[13:0] : 14'd0) : g15[13:0];
    assign vga_dac_o = an_att[13:6];

    // gain falls with level
    // Gain is 1 + 3*dg_att/2^14, a linear approximation of the dB span.
    wire [15:0]     gmul   = 16'h4000 + 16'({2'b00, dg_att} + {1'b0, dg_att, 1'b0});
    wire [DW+15:0]  prod_i = $signed(dec_i_i) * $signed({1'b0, gmul});
    wire [DW+15:0]  prod_q = $signed(dec_q_i) * $signed({1'b0, gmul});

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            g_i   <= '0;
            g_q   <= '0;
            g_vld <= 1'b0;
        end
        else
        begin
            g_vld <= dec_vld_i;
            if (dec_vld_i)
            begin
                g_i <= prod_i[DW+13:14];
                g_q <= prod_q[DW+13:14];
            end
        end
    end

    // gain four drops two top bits
    agcl_shaper #(.IW(DW), .OW(OW)) u_shp_i (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .vld_i   (g_vld),
        .d_i     (g_i),
        .q_o     (out_i_o)
    );
    agcl_shaper #(.IW(DW), .OW(OW)) u_shp_q (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .vld_i   (g_vld),
        .d_i     (g_q),
        .q_o     (out_q_o)
    );

    // Full width outputs serve hosts that prefer 24-bit data over digital gain.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wide_i_o  <= '0;
            wide_q_o  <= '0;
            out_vld_o <= 1'b0;
        end
        else
        begin
            out_vld_o <= g_vld;
            if (g_vld)
            begin
                wide_i_o <= g_i;
                wide_q_o <= g_q;
            end
        end
    end

    assign fast_acquire_o     = r_ctl[FAST_BIT];
    assign front_attenuator_o = r_gain_hi[FRONT_BIT];
    assign loop_aux_bit_o     = r_ctl[AUX_BIT];
endmodule : agcl_loop
`default_nettype wire

//--- agcl_front_model.sv
// Model of the decimation chain that feeds the gain control loop.
`timescale 1ns/1ps
`default_nettype none
module agcl_front_model #(
    parameter int VLD_GAP = 8
)(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [23:0] amp_i,
    output logic      [23:0] first_decimator_i_o = 24'h00_0000,
    output logic      [23:0] first_decimator_q_o = 24'h00_0000,
    output logic             dec_vld_o = 1'b0,
    output logic      [23:0] dec_i_o = 24'h00_0000,
    output logic      [23:0] dec_q_o = 24'h00_0000
);
    int cnt = 0;
    always @(negedge clk_i)
    begin
        cnt = (!rst_n_i || cnt == VLD_GAP - 1) ? 0 : cnt + 1;
        first_decimator_i_o <= cnt[0] ? amp_i : -amp_i;
        first_decimator_q_o <= amp_i;
        dec_vld_o <= rst_n_i && cnt == 0;
        // Lanes toggle between samples so stale data never looks valid.
        dec_i_o <= (cnt == 0) ? amp_i : ~dec_i_o;
        dec_q_o <= (cnt == 0) ? -amp_i : ~dec_q_o;
    end
endmodule : agcl_front_model
`default_nettype wire

//--- agcl_loop_properties.sv
// Port checker for the gain control loop.
`timescale 1ns/1ps
`default_nettype none
module agcl_loop_properties
    import agcl_pkg::*;
#(
    parameter int DW = 24,
    parameter int OW = 16
)(
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic          reg_wr_i,
    input wire logic [2:0]    reg_addr_i,
    input wire logic [7:0]    reg_wdata_i,
    input wire logic [7:0]    reg_rdata_o,
    input wire logic          digital_gain_stage_en_i,
    input wire logic          dec_vld_i,
    input wire logic [DW-1:0] dec_i_i,
    input wire logic          out_vld_o,
    input wire logic [OW-1:0] out_i_o,
    input wire logic [DW-1:0] wide_i_o,
    input wire logic [7:0]    vga_dac_o,
    input wire logic          fast_acquire_o,
    input wire logic          front_attenuator_o,
    input wire logic          loop_aux_bit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       loop_on;
    logic [6:0] gap;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            loop_on <= 1'b0;
        else if (reg_wr_i && reg_addr_i == REG_LOOP_CTL)
            loop_on <= reg_wdata_i[2:0] != 3'h0 && reg_wdata_i[2:0] <= 3'h5;
    end
    // A loop-off load may move the code at any time, so spacing is judged only with the loop on.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || $changed(vga_dac_o))
            gap <= 7'h00;
        else if (gap != 7'h7F)
            gap <= gap + 7'h01;
    end
    property p_out_lat;
        out_vld_o == $past(dec_vld_i, 2);
    endproperty
    a_out_lat: assert property (p_out_lat) else $error("output valid latency wrong");
    property p_wide_unity;
        out_vld_o && !$past(digital_gain_stage_en_i, 2) |-> wide_i_o == $past(dec_i_i, 2);
    endproperty
    a_wide_unity: assert property (p_wide_unity) else $error("unity gain changed data");
    property p_analog_unity;
        out_vld_o && $past(digital_gain_stage_en_i, 2) && $past(vga_dac_o, 2) != 8'h00
            |-> wide_i_o == $past(dec_i_i, 2);
    endproperty
    a_analog_unity: assert property (p_analog_unity) else $error("analog attenuation early");
    property p_slice;
        out_vld_o && !$past(digital_gain_stage_en_i, 2) && wide_i_o[7:0] == 8'h00 |-> out_i_o == wide_i_o[23:8];
    endproperty
    a_slice: assert property (p_slice) else $error("narrow output not top bits");
    property p_unmapped;
        reg_addr_i < REG_GAIN_HI || reg_addr_i > REG_LOOP_CTL |-> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctl_bits;
        reg_wr_i && reg_addr_i == REG_LOOP_CTL |=> fast_acquire_o == $past(reg_wdata_i[3])
            && loop_aux_bit_o == $past(reg_wdata_i[7]);
    endproperty
    a_ctl_bits: assert property (p_ctl_bits) else $error("control bits not taken");
    property p_front;
        reg_wr_i && reg_addr_i == REG_GAIN_HI |=> front_attenuator_o == $past(reg_wdata_i[7]);
    endproperty
    a_front: assert property (p_front) else $error("front attenuator bit not taken");
    property p_tick;
        loop_on && $changed(vga_dac_o) |-> gap >= 7'h3B;
    endproperty
    a_tick: assert property (p_tick) else $error("loop updated between ticks");
    property p_no_wrap;
        loop_on && $past(vga_dac_o) >= 8'hC0 |-> vga_dac_o >= 8'h40;
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("attenuation wrapped");
    property p_rst;
        @(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> !out_vld_o && vga_dac_o == 8'h00 && !fast_acquire_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    c_digital_gain_stage: cover property (out_vld_o && digital_gain_stage_en_i);
    c_loop_tick: cover property (loop_on && $changed(vga_dac_o));
    c_high: cover property (loop_on && vga_dac_o >= 8'hC0);
endmodule : agcl_loop_properties
bind agcl_loop agcl_loop_properties #(.DW(DW), .OW(OW)) u_agcl_loop_properties (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .digital_gain_stage_en_i(digital_gain_stage_en_i),
    .dec_vld_i(dec_vld_i), .dec_i_i(dec_i_i), .out_vld_o(out_vld_o), .out_i_o(out_i_o),
    .wide_i_o(wide_i_o), .vga_dac_o(vga_dac_o), .fast_acquire_o(fast_acquire_o),
    .front_attenuator_o(front_attenuator_o), .loop_aux_bit_o(loop_aux_bit_o));
`default_nettype wire

//--- test_agcl_loop.sv
// Self-checking bench for the gain control loop.
`timescale 1ns/1ps
`default_nettype none
module test_agcl_loop
    import agcl_pkg::*;
;
    typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} agcl_row_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        digital_gain_stage = 1'b0;
    logic        adc_rst = 1'b0;
    logic [23:0] amp = 24'h00_0000;
    logic [23:0] d1i, d1q, di, dq, wi, wq, cap, cap_q;
    logic        dvld, ovld, fa, fr, aux;
    logic [15:0] oi, oq;
    logic [7:0]  rd, vga, v1, v2;
    int          error_cnt = 0;
    int          n_compared = 0;
    agcl_row_s   rows [6] = '{'{3'h5, 8'hA5, 8'hA5}, '{3'h6, 8'hC8, 8'hC8},
        '{3'h7, 8'hFF, 8'h00}, '{3'h2, 8'h5A, 8'h00}, '{3'h4, 8'h3C, 8'h3C},
        '{3'h3, 8'h80, 8'h80}};
    agcl_loop u_agcl_loop (.clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rd), .digital_gain_stage_en_i(digital_gain_stage), .adc_reset_i(adc_rst),
        .first_decimator_i_i(d1i), .first_decimator_q_i(d1q), .dec_vld_i(dvld), .dec_i_i(di), .dec_q_i(dq),
        .out_vld_o(ovld), .out_i_o(oi), .out_q_o(oq), .wide_i_o(wi), .wide_q_o(wq),
        .vga_dac_o(vga), .fast_acquire_o(fa), .front_attenuator_o(fr), .loop_aux_bit_o(aux));
    agcl_front_model u_agcl_front_model (.clk_i(clk), .rst_n_i(rst_n), .amp_i(amp),
        .first_decimator_i_o(d1i), .first_decimator_q_o(d1q), .dec_vld_o(dvld), .dec_i_o(di), .dec_q_o(dq));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        #1;
        chk("reg_read", {16'h0000, e}, {16'h0000, rd});
    endtask : rd_chk
    // Sample taken at the valid edge is due two edges later.
    task automatic grab;
        @(posedge clk iff dvld);
        cap = di;
        cap_q = dq;
        repeat (2) @(posedge clk);
        #1;
    endtask : grab
    task automatic report_and_stop;
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int a = 3; a < 7; a++)
            rd_chk(3'(a), REG_RESET_VAL);
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        chk("ctl_bits", 24'h00_0007, {21'h0, fa, fr, aux});
        amp = 24'h12_3400;
        for (int k = 0; k < 3; k++)
        begin
            grab();
            chk("wide", cap, wi);
            chk("narrow", {8'h00, cap[23:8]}, {8'h00, oi});
            chk("wide_q", cap_q, wq);
            chk("narrow_q", {8'h00, cap_q[23:8]}, {8'h00, oq});
        end
        wr_reg(REG_GAIN_HI, 8'h3F);
        wr_reg(REG_GAIN_LO, 8'hFF);
        repeat (130) @(negedge clk);
        chk("vga_load", 24'h00_00FF, {16'h0000, vga});
        // Start low, and let the manual code settle before the loop takes over.
        wr_reg(REG_GAIN_HI, 8'h00);
        wr_reg(REG_ATK_DCY, 8'hF0);
        amp = 24'h7F_FF00;
        repeat (64) @(negedge clk);
        wr_reg(REG_LOOP_CTL, 8'h01);
        repeat (130) @(negedge clk);
        v1 = vga;
        repeat (600) @(negedge clk);
        v2 = vga;
        chk("vga_rise", 24'h00_0001, {23'h0, v2 > v1 && v1 != 8'h00});
        chk("vga_clamp", 24'h00_00FF, {16'h0000, v2});
        amp = 24'h00_0000;
        repeat (3000) @(negedge clk);
        chk("vga_fall", 24'h00_0001, {23'h0, vga < v2});
        chk("vga_floor", 24'h00_0000, {16'h0000, vga});
        // Slowest attack keeps the normal step small beside the overload ramp.
        wr_reg(REG_ATK_DCY, 8'h00);
        adc_rst = 1'b1;
        repeat (300) @(negedge clk);
        chk("vga_slow", 24'h00_0001, {23'h0, vga != 8'h00 && vga < 8'h40});
        wr_reg(REG_LOOP_CTL, 8'h71);
        v1 = vga;
        repeat (300) @(negedge clk);
        chk("vga_reset", 24'h00_0001, {23'h0, vga > v1});
        chk("vga_fast", 24'h00_00FF, {16'h0000, vga});
        adc_rst = 1'b0;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(REG_LOOP_CTL, REG_RESET_VAL);
        digital_gain_stage = 1'b1;
        amp = 24'h00_1000;
        wr_reg(REG_ATK_DCY, 8'hC0);
        wr_reg(REG_LOOP_CTL, 8'h05);
        repeat (600) @(negedge clk);
        grab();
        chk("digital_gain_stage_gain", 24'h00_0001, {23'h0, wi > cap && wi <= cap * 4});
        amp = 24'h7F_FF00;
        repeat (3000) @(negedge clk);
        grab();
        chk("digital_gain_stage_unity", cap, wi);
        chk("analog_att", 24'h00_0001, {23'h0, vga != 8'h00});
        report_and_stop();
    end
endmodule : test_agcl_loop
`default_nettype wire
